// ===== pkg/ext_mode_pkg.sv
package ext_mode_pkg;

  // Load-mode word: bank select on ba, value on address bits (bank address bit 2 is bit 16)
  localparam int WORD_W        = 17;
  localparam int BANK_W        = 2;
  localparam int COL_W         = 3;
  localparam int LAT_W         = 4;

  // Bank codes carried with a load-mode command
  localparam logic [1:0] BANK_MODE = 2'h0;
  localparam logic [1:0] BANK_EXT  = 2'h1;
  localparam logic [1:0] BANK_EXT2 = 2'h2;

  // Extended word fields
  localparam int BIT_DLL_DIS   = 0;
  localparam int BIT_DRIVE_RED = 1;
  localparam int BIT_TERM_LO   = 2;
  localparam int POST_LSB      = 3;
  localparam int BIT_TERM_HI   = 6;
  localparam int CAL_LSB       = 7;
  localparam int BIT_STROBE_SE = 10;
  localparam int BIT_RSTROBE   = 11;
  localparam int BIT_OUT_DIS   = 12;
  // Second extended word field
  localparam int BIT_FAST_REF  = 7;
  // Base word column latency field and dll reset bit
  localparam int COL_LSB       = 4;
  localparam int BIT_DLL_RST   = 8;

  // Reset values (contents undefined at power-up; zero chosen)
  localparam logic [WORD_W-1:0] EXT_RESET  = 17'h00000;
  localparam logic [WORD_W-1:0] EXT2_RESET = 17'h00000;

  // Latency limits
  localparam logic [2:0] POST_MAX = 3'h6;
  localparam logic [2:0] COL_MIN  = 3'h3;
  localparam logic [2:0] COL_MAX  = 3'h7;
  localparam logic [LAT_W-1:0] ONE_CLK = 4'h1;

  // Termination codes {E6,E2}
  typedef enum logic [1:0] {
    TERM_OFF  = 2'b00,
    TERM_75   = 2'b01,
    TERM_150  = 2'b10,
    TERM_50   = 2'b11
  } term_sel_t;

  // Power state of the core as seen by termination gating
  typedef enum logic [2:0] {
    PST_IDLE    = 3'b000,
    PST_ACTIVE  = 3'b001,
    PST_ACT_PD  = 3'b010,
    PST_PRE_PD  = 3'b011,
    PST_SELF    = 3'b100
  } pwr_state_t;

  // Load-mode command as it arrives
  typedef struct packed {
    logic              valid;
    logic [BANK_W-1:0] bank;
    logic [WORD_W-1:0] word;
  } load_cmd_t;

  // Decoded configuration handed to the core
  typedef struct packed {
    logic             dll_on;
    logic             dll_reset;
    logic             drive_reduced;
    term_sel_t        term_sel;
    logic [2:0]       posted_additive_latency;
    logic [2:0]       driver_calibration_field;
    logic             strobe_complement_en;
    logic             redundant_read_strobe_en;
    logic             redundant_read_strobe_complement_en;
    logic             outputs_disabled;
    logic             fast_refresh;
  } ext_cfg_t;

  // Computed latencies
  typedef struct packed {
    logic [LAT_W-1:0] read_latency;
    logic [LAT_W-1:0] write_latency;
  } lat_t;

endpackage : ext_mode_pkg

// ===== hdl/ext_latency_calc.sv
`timescale 1ns/100ps
// Registered read and write latency from the posted and column latencies
module ext_latency_calc (
  // Clock and reset
  input  wire logic                     i_clk,
  input  wire logic                     i_rst,
  // Latency fields
  input  wire logic [2:0]               i_posted_additive_latency,
  input  wire logic [2:0]               i_column_latency,
  // Result
  output ext_mode_pkg::lat_t            o_lat
);
  import ext_mode_pkg::*;

  logic [LAT_W-1:0] rd_lat_next;

  // Read latency is the sum; write latency one clock less
  always_comb begin
    rd_lat_next = LAT_W'(i_posted_additive_latency) + LAT_W'(i_column_latency); // see R20
  end

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_lat <= '0;
    end else begin
      o_lat.read_latency  <= rd_lat_next;
      o_lat.write_latency <= rd_lat_next - ONE_CLK; // see R20
    end
  end

endmodule : ext_latency_calc

// ===== hdl/ddr2_extended_mode_config.sv
`timescale 1ns/100ps
// Contract
// R01 - Capture and hold extended word on load
// R02 - Controller loads only with banks idle
// R03 - Controller writes reserved bits as zero
// R04 - Bit 0 controls loop; enable needs reset
// R05 - Self refresh stops loop, exit resets it
// R06 - Controller waits 200 clocks before read
// R07 - Slow, loop off: precharge after refresh
// R08 - Bit 1 selects full or reduced drive
// R09 - Bit 10 makes strobe single-ended
// R10 - Redundant complement needs bit11 set, bit10 clear
// R11 - Redundant strobe mirrors strobe on reads
// R12 - Bit 12 disables data and strobe outputs
// R13 - Bits 6,2 pick termination value
// R14 - Termination input honoured in three states
// R15 - Controller keeps termination off until load
// R16 - Controller waits eight clocks before termination
// R17 - Controller leaves calibration bits at default
// R18 - Bits 5..3 give posted latency 0..6
// R19 - Commands held for posted latency
// R20 - Read latency sum; write one less
// R21 - Second word bit 7 selects fast refresh
// R22 - Column latency three to seven clocks
module ddr2_extended_mode_config (
  // Clock and reset
  input  wire logic                        i_clk,
  input  wire logic                        i_rst,
  // Load-mode command
  input  ext_mode_pkg::load_cmd_t          i_load_mode_command,
  // Core state and strobes
  input  ext_mode_pkg::pwr_state_t         i_pwr_state,
  input  wire logic                        i_termination_control_input,
  input  wire logic                        i_x8_config,
  input  wire logic                        i_read_active,
  input  wire logic                        i_strobe,
  // Read and write commands to be posted
  input  wire logic                        i_rd_cmd,
  input  wire logic                        i_wr_cmd,
  // Decoded configuration
  output ext_mode_pkg::ext_cfg_t           o_cfg,
  output ext_mode_pkg::lat_t               o_lat,
  output logic [2:0]                       o_column_latency,
  // Live pin controls
  output logic                             o_dll_running,
  output logic                             o_term_on,
  output ext_mode_pkg::term_sel_t          o_term_value,
  output logic                             o_data_oe,
  output logic                             o_strobe_oe,
  output logic                             o_strobe_n_oe,
  output logic                             o_rstrobe_o,
  output logic                             o_rstrobe_oe,
  output logic                             o_rstrobe_n_oe,
  // Posted commands issued internally
  output logic                             o_int_rd,
  output logic                             o_int_wr
);
  import ext_mode_pkg::*;

  logic [WORD_W-1:0] ext_reg;
  logic [WORD_W-1:0] ext2_reg;
  logic [COL_W-1:0]  col_lat_reg;
  logic              self_q_reg;
  logic              dll_reset_reg;
  logic [7:0]        rd_pipe_reg;
  logic [7:0]        wr_pipe_reg;
  logic [2:0]        post_lat;
  logic              ld_ext;
  logic              ld_ext2;
  logic              ld_mode;
  logic              in_self;
  logic              term_allowed;
  logic              strobe_ok;

  // Clamp a three-bit field into a legal range
  function automatic logic [2:0] clamp3(input logic [2:0] v, input logic [2:0] lo, input logic [2:0] hi);
    if (v < lo) begin
      clamp3 = lo;
    end else if (v > hi) begin
      clamp3 = hi;
    end else begin
      clamp3 = v;
    end
  endfunction : clamp3

  // Load decode
  assign ld_mode = i_load_mode_command.valid && (i_load_mode_command.bank == BANK_MODE);
  assign ld_ext  = i_load_mode_command.valid && (i_load_mode_command.bank == BANK_EXT);
  assign ld_ext2 = i_load_mode_command.valid && (i_load_mode_command.bank == BANK_EXT2);
  assign in_self = (i_pwr_state == PST_SELF);
  // Reserved encodings fall back to the nearest legal value instead of undefined behaviour
  assign post_lat = clamp3(ext_reg[POST_LSB +: 3], 3'h0, POST_MAX); // see R18

  // Extended word; array contents are elsewhere and never touched here
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ext_reg <= EXT_RESET;
    end else if (ld_ext) begin
      ext_reg <= i_load_mode_command.word; // see R01
    end
  end

  // Second extended word
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      ext2_reg <= EXT2_RESET;
    end else if (ld_ext2) begin
      ext2_reg <= i_load_mode_command.word; // see R21
    end
  end

  // Column latency taken from the base word load
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      col_lat_reg <= COL_MIN;
    end else if (ld_mode) begin
      col_lat_reg <= clamp3(i_load_mode_command.word[COL_LSB +: COL_W], COL_MIN, COL_MAX); // see R22
    end
  end

  // Loop reset pulse: base-word reset bit, or leaving self refresh
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      self_q_reg    <= 1'b0;
      dll_reset_reg <= 1'b0;
    end else begin
      self_q_reg    <= in_self;
      dll_reset_reg <= (ld_mode && i_load_mode_command.word[BIT_DLL_RST]) // see R04
                       || (self_q_reg && !in_self); // see R05
    end
  end

  // Loop runs when enabled and not in self refresh
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_dll_running <= 1'b0;
    end else begin
      o_dll_running <= !ext_reg[BIT_DLL_DIS] && !in_self; // see R04 see R05
    end
  end

  // Decoded configuration outputs
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_cfg <= '0;
    end else begin
      o_cfg.dll_on                   <= !ext_reg[BIT_DLL_DIS];
      o_cfg.dll_reset                <= dll_reset_reg;
      o_cfg.drive_reduced            <= ext_reg[BIT_DRIVE_RED]; // see R08
      o_cfg.term_sel                 <= term_sel_t'({ext_reg[BIT_TERM_HI], ext_reg[BIT_TERM_LO]}); // see R13
      o_cfg.posted_additive_latency  <= post_lat;
      o_cfg.driver_calibration_field <= ext_reg[CAL_LSB +: 3];
      o_cfg.strobe_complement_en     <= !ext_reg[BIT_STROBE_SE]; // see R09
      o_cfg.redundant_read_strobe_en <= ext_reg[BIT_RSTROBE] && i_x8_config;
      o_cfg.redundant_read_strobe_complement_en <=
        ext_reg[BIT_RSTROBE] && !ext_reg[BIT_STROBE_SE] && i_x8_config; // see R10
      o_cfg.outputs_disabled         <= ext_reg[BIT_OUT_DIS]; // see R12
      o_cfg.fast_refresh             <= ext2_reg[BIT_FAST_REF]; // see R21
    end
  end

  assign o_column_latency = col_lat_reg;

  // Termination: pin only counts in active and power-down states
  assign term_allowed = (i_pwr_state == PST_ACTIVE) || (i_pwr_state == PST_ACT_PD)
                        || (i_pwr_state == PST_PRE_PD); // see R14

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_term_on    <= 1'b0;
      o_term_value <= TERM_OFF;
    end else begin
      o_term_value <= term_sel_t'({ext_reg[BIT_TERM_HI], ext_reg[BIT_TERM_LO]});
      o_term_on    <= ({ext_reg[BIT_TERM_HI], ext_reg[BIT_TERM_LO]} != TERM_OFF)
                      && term_allowed && i_termination_control_input; // see R14
    end
  end

  // Output drivers; output-disable overrides every output enable
  assign strobe_ok = !ext_reg[BIT_OUT_DIS] && i_read_active;
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_data_oe      <= 1'b0;
      o_strobe_oe    <= 1'b0;
      o_strobe_n_oe  <= 1'b0;
      o_rstrobe_o    <= 1'b0;
      o_rstrobe_oe   <= 1'b0;
      o_rstrobe_n_oe <= 1'b0;
    end else begin
      o_data_oe      <= strobe_ok; // see R12
      o_strobe_oe    <= strobe_ok;
      // Complement ball floats when single-ended
      o_strobe_n_oe  <= strobe_ok && !ext_reg[BIT_STROBE_SE]; // see R09
      // Redundant strobe follows strobe every cycle; its enable is on during reads only, off for writes
      o_rstrobe_o    <= i_strobe; // see R11
      o_rstrobe_oe   <= strobe_ok && i_x8_config && ext_reg[BIT_RSTROBE]; // see R11
      o_rstrobe_n_oe <= strobe_ok && i_x8_config && ext_reg[BIT_RSTROBE]
                        && !ext_reg[BIT_STROBE_SE]; // see R10
    end
  end

  // Posting pipelines: command issued internally post_lat+1 clocks after it arrives
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      rd_pipe_reg <= 8'h00;
      wr_pipe_reg <= 8'h00;
      o_int_rd    <= 1'b0;
      o_int_wr    <= 1'b0;
    end else begin
      rd_pipe_reg <= {rd_pipe_reg[6:0], i_rd_cmd};
      wr_pipe_reg <= {wr_pipe_reg[6:0], i_wr_cmd};
      o_int_rd    <= (post_lat == 3'h0) ? i_rd_cmd : rd_pipe_reg[post_lat - 3'h1]; // see R19
      o_int_wr    <= (post_lat == 3'h0) ? i_wr_cmd : wr_pipe_reg[post_lat - 3'h1]; // see R19
    end
  end

  // Latency arithmetic
  ext_latency_calc u_lat (
    .i_clk                     (i_clk),
    .i_rst                     (i_rst),
    .i_posted_additive_latency (post_lat),
    .i_column_latency          (col_lat_reg),
    .o_lat                     (o_lat)
  );

endmodule : ddr2_extended_mode_config

// ===== test/ext_mode_asserts.sv
`timescale 1ns/100ps
module ext_mode_asserts
  import ext_mode_pkg::*;
(
  // Clock and reset
  input wire logic                i_clk,
  input wire logic                i_rst,
  // Watched ports
  input ext_mode_pkg::load_cmd_t  i_load_mode_command,
  input ext_mode_pkg::pwr_state_t i_pwr_state,
  input wire logic                i_termination_control_input,
  input wire logic                i_rd_cmd,
  input ext_mode_pkg::ext_cfg_t   o_cfg,
  input wire logic                o_term_on,
  input ext_mode_pkg::term_sel_t  o_term_value,
  input wire logic                o_data_oe,
  input wire logic                o_strobe_oe,
  input wire logic                o_int_rd
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  // Load decode shared by the field checks
  wire              ld1 = i_load_mode_command.valid && i_load_mode_command.bank == BANK_EXT;
  wire              ld2 = i_load_mode_command.valid && i_load_mode_command.bank == BANK_EXT2;
  wire              ld0 = i_load_mode_command.valid && i_load_mode_command.bank == BANK_MODE;
  wire [WORD_W-1:0] w   = i_load_mode_command.word;
  sequence s_sr_exit;
    $past(i_pwr_state) == PST_SELF && i_pwr_state != PST_SELF;
  endsequence
  sequence s_rd_post2;
    i_rd_cmd && o_cfg.posted_additive_latency == 3'h2 && $stable(o_cfg.posted_additive_latency);
  endsequence
  // Loop reset is a single-cycle pulse
  sequence s_rst_pulse;
    o_cfg.dll_reset ##1 !o_cfg.dll_reset;
  endsequence
  AST_DLL_EN: assert property (ld1 |-> ##2 o_cfg.dll_on == !$past(w[0], 2))
    else $error("loop enable field not applied");
  AST_DRIVE: assert property (ld1 |-> ##2 o_cfg.drive_reduced == $past(w[1], 2))
    else $error("drive field not applied");
  AST_TERM_SEL: assert property (ld1 |-> ##2 o_cfg.term_sel == {$past(w[6], 2), $past(w[2], 2)})
    else $error("termination code not applied");
  AST_FAST_REF: assert property (ld2 |-> ##2 o_cfg.fast_refresh == $past(w[7], 2))
    else $error("refresh rate bit not applied");
  AST_HOLD: assert property ((!ld1)[*2] |-> ##2 $stable(o_cfg.drive_reduced) && $stable(o_cfg.term_sel))
    else $error("extended fields changed without a load");
  AST_SR_EXIT: assert property (s_sr_exit |-> ##2 o_cfg.dll_reset)
    else $error("no loop reset on self refresh exit");
  AST_DLL_RST: assert property (ld0 && w[BIT_DLL_RST] |-> ##2 s_rst_pulse)
    else $error("no single loop reset pulse after base word load");
  AST_TERM: assert property (o_term_on |-> $past(i_termination_control_input) && o_term_value != TERM_OFF &&
    $past(i_pwr_state) inside {PST_ACTIVE, PST_ACT_PD, PST_PRE_PD}) else $error("termination on without cause");
  AST_OUT_DIS: assert property (o_cfg.outputs_disabled[*2] |-> !o_data_oe && !o_strobe_oe)
    else $error("outputs driven while disabled");
  AST_RD_POST: assert property (s_rd_post2 |-> ##3 o_int_rd)
    else $error("posted read not issued after latency");
endmodule : ext_mode_asserts

// ===== test/ddr2_ctrl_model.sv
`timescale 1ns/100ps
module ddr2_ctrl_model
  import ext_mode_pkg::*;
#(parameter int MODE_SET_DELAY = 2)
(
  // Clock
  input  wire logic                i_clk,
  // Controller side of the device
  output ext_mode_pkg::load_cmd_t  o_cmd,
  output ext_mode_pkg::pwr_state_t o_pwr,
  output logic                     o_term,
  output logic                     o_rd
);
  int cyc    = 0;
  int ext_at = 1 << 30;
  int dll_at = 0;
  // Cycle count for the spacing rules
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
  end
  // Idle controller, termination low until configured
  initial begin
    o_cmd  = '0;
    o_pwr  = PST_IDLE;
    o_term = 1'b0;
    o_rd   = 1'b0; // No auto-refresh is ever issued, so no precharge-all is owed
  end
  // Loads only from idle, reserved and calibration bits cleared
  task automatic load(input logic [1:0] b, input logic [WORD_W-1:0] v);
    @(posedge i_clk);
    #1;
    o_pwr = PST_IDLE;
    o_cmd = '{1'b1, b, v & ((b == BANK_EXT) ? 17'h01c7f : 17'h01fff)};
    if (b == BANK_EXT) begin
      ext_at = cyc;
    end
    if (b == BANK_MODE && v[BIT_DLL_RST]) begin
      dll_at = cyc;
    end
    @(posedge i_clk);
    #1;
    o_cmd.valid = 1'b0;
    repeat (MODE_SET_DELAY) @(posedge i_clk);
    #1;
  endtask : load
  // Termination waits for the extended load plus eight clocks
  task automatic term(input logic v);
    while (v && cyc < ext_at + 8) @(posedge i_clk);
    @(posedge i_clk);
    #1;
    o_term = v;
  endtask : term
  // Termination dropped a clock before self refresh
  task automatic pwr(input pwr_state_t s);
    @(posedge i_clk);
    #1;
    if (s == PST_SELF) begin
      o_term = 1'b0;
      @(posedge i_clk);
      #1;
    end
    o_pwr = s;
  endtask : pwr
  // Read held back until the loop has had its clocks
  task automatic rd();
    while (cyc < dll_at + 200) @(posedge i_clk);
    @(posedge i_clk);
    #1;
    o_rd = 1'b1;
    @(posedge i_clk);
    #1;
    o_rd = 1'b0;
  endtask : rd
endmodule : ddr2_ctrl_model

// ===== test/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import ext_mode_pkg::*;
  logic       i_clk, i_rst, i_x8_config, i_read_active, i_strobe, i_wr_cmd;
  load_cmd_t  cmd;
  pwr_state_t pst;
  ext_cfg_t   cfg;
  lat_t       lat;
  term_sel_t  tval;
  logic [2:0] col_lat;
  logic       term, rd, dll_run, term_on, data_oe, s_oe, sn_oe, int_rd, int_wr, rs_o, rs_oe, rsn_oe;
  int         num_errors, n_checks, cycles, k;
  logic [16:0] words [11] = '{17'h00001, 17'h00002, 17'h00004, 17'h00040, 17'h00044, 17'h00400,
                              17'h00800, 17'h00c00, 17'h01000, 17'h00038, 17'h00030};
  ddr2_ctrl_model u_ctrl (.i_clk(i_clk), .o_cmd(cmd), .o_pwr(pst), .o_term(term), .o_rd(rd));
  ddr2_extended_mode_config uut (.i_clk(i_clk), .i_rst(i_rst), .i_load_mode_command(cmd), .i_pwr_state(pst),
    .i_termination_control_input(term), .i_x8_config(i_x8_config), .i_read_active(i_read_active),
    .i_strobe(i_strobe), .i_rd_cmd(rd), .i_wr_cmd(i_wr_cmd), .o_cfg(cfg), .o_lat(lat), .o_column_latency(col_lat),
    .o_dll_running(dll_run), .o_term_on(term_on), .o_term_value(tval), .o_data_oe(data_oe), .o_strobe_oe(s_oe),
    .o_strobe_n_oe(sn_oe), .o_rstrobe_o(rs_o), .o_rstrobe_oe(rs_oe), .o_rstrobe_n_oe(rsn_oe), .o_int_rd(int_rd),
    .o_int_wr(int_wr));
  // Clock and watchdog
  always #5 i_clk = ~i_clk;
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic chk(input string n, input logic [16:0] e, input logic [16:0] g);
    n_checks++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      num_errors++;
    end
  endtask : chk
  task automatic wt(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask : wt
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : complete_run
  // Expected decode; x8 part, so redundant strobe follows bit 11; reserved posted code falls to the maximum
  function automatic ext_cfg_t exp_cfg(input logic [16:0] v, input logic fr);
    exp_cfg = '{!v[0], 1'b0, v[1], term_sel_t'({v[6], v[2]}), (v[5:3] > POST_MAX) ? POST_MAX : v[5:3], 3'h0,
                !v[10], v[11], v[11] & !v[10], v[12], fr};
  endfunction : exp_cfg
  // Main sequence
  initial begin
    {i_clk, i_rst, i_x8_config, i_read_active, i_strobe, i_wr_cmd} = 6'b011100;
    {num_errors, n_checks, cycles} = '0;
    wt(16);
    i_rst = 1'b0;
    wt(3);
    chk("column latency", 17'h3, col_lat);
    chk("latencies", 17'h32, lat);
    $display("test reset done");
    foreach (words[i]) begin
      u_ctrl.load(BANK_EXT, words[i]);
      chk("ext fields", exp_cfg(words[i], 1'b0), cfg);
      chk("data oe", !words[i][12], data_oe);
      chk("strobe oe", !words[i][12], s_oe);
      chk("strobe n oe", !words[i][10] & !words[i][12], sn_oe);
      chk("redundant oe", words[i][11] & !words[i][12], rs_oe);
      chk("redundant n oe", words[i][11] & !words[i][10] & !words[i][12], rsn_oe);
    end
    wt(2);
    chk("latencies", 17'h98, lat);
    u_ctrl.load(BANK_EXT2, 17'h00080);
    u_ctrl.load(2'h3, 17'h00001);
    chk("fast refresh", exp_cfg(17'h00030, 1'b1), cfg);
    $display("test fields done");
    u_ctrl.load(BANK_EXT, 17'h00010);
    u_ctrl.load(BANK_MODE, 17'h00150);
    wt(2);
    chk("column latency", 17'h5, col_lat);
    chk("latencies", 17'h76, lat);
    u_ctrl.rd();
    k = 0;
    while (int_rd !== 1'b1 && k < 10) begin
      wt(1);
      k++;
    end
    chk("posted read", 17'h2, k[16:0]);
    i_wr_cmd = 1'b1;
    wt(1);
    i_wr_cmd = 1'b0;
    k = 0;
    while (int_wr !== 1'b1 && k < 10) begin
      wt(1);
      k++;
    end
    chk("posted write", 17'h2, k[16:0]);
    $display("test posted commands done");
    u_ctrl.load(BANK_EXT, 17'h00004);
    u_ctrl.term(1'b1);
    wt(2);
    chk("term idle", 17'h0, term_on);
    u_ctrl.pwr(PST_ACTIVE);
    wt(2);
    chk("term on", 17'h1, term_on);
    chk("term value", 17'h1, tval);
    u_ctrl.pwr(PST_SELF);
    wt(3);
    chk("loop stopped", 17'h0, dll_run);
    u_ctrl.pwr(PST_IDLE);
    wt(3);
    chk("loop running", 17'h1, dll_run);
    $display("test termination done");
    u_ctrl.load(BANK_EXT, 17'h00800);
    i_strobe = 1'b1;
    wt(2);
    chk("redundant strobe", 17'h1, rs_o);
    chk("redundant oe read", 17'h1, rs_oe);
    {i_x8_config, i_read_active} = 2'b01;
    wt(2);
    chk("redundant oe x4", 17'h0, rs_oe);
    chk("redundant cfg x4", 17'h0, cfg.redundant_read_strobe_en);
    {i_x8_config, i_read_active} = 2'b10;
    wt(2);
    chk("redundant oe write", 17'h0, rs_oe);
    chk("data oe write", 17'h0, data_oe);
    u_ctrl.load(BANK_MODE, 17'h00010);
    chk("column latency floor", 17'h3, col_lat);
    $display("test strobes done");
    complete_run();
  end
endmodule : tb_top
bind ddr2_extended_mode_config ext_mode_asserts u_chk (.i_clk, .i_rst, .i_load_mode_command, .i_pwr_state,
  .i_termination_control_input, .i_rd_cmd, .o_cfg, .o_term_on, .o_term_value, .o_data_oe, .o_strobe_oe, .o_int_rd);
